// ---- rtl/pba_defines.svh ----
// Constants of the transient absorption and phase adjust block.
// Included by every design module; holds definitions only.
`ifndef PBA_DEFINES_SVH
`define PBA_DEFINES_SVH
// Register offsets
`define PBA_OFF_CTRL 8'h48
`define PBA_OFF_ADJ_LO 8'h70
`define PBA_OFF_ADJ_HI 8'h71
`define PBA_OFF_SYS 8'h72
`define PBA_OFF_THR 8'h76
// Control register fields
`define PBA_CTRL_FLAG 0
`define PBA_CTRL_REQ 1
`define PBA_CTRL_EN 2
`define PBA_CTRL_FRZ 3
`define PBA_CTRL_HOLD 4
// Threshold register fields
`define PBA_THR_CODE_HI 3
`define PBA_THR_AUTO_EN 4
`define PBA_THR_AUTO_TRIG 5
`define PBA_THR_RUN 6
// Reset values
`define PBA_RST_EN 1'b1
`define PBA_RST_THR_CODE 4'h0
// Field limits
`define PBA_THR_CODE_MAX 4'hA
`define PBA_SYS_MAX 8'sh0D
`define PBA_ADJ_MAX 17'sh08235
`define PBA_BW_MAX 5'h11
`define PBA_NUM_REFS 4
// Step sizes in picoseconds
`define PBA_SYS_STEP_PS 8'h65
`define PBA_ADJ_STEP_PS 4'h6
// Times in their own units
`define PBA_CLK_NS 40
`define PBA_INTERVAL_NS 100000000
`define PBA_MOVE_NS 156
`define PBA_THR_BASE_NS 1000
`define PBA_THR_STEP_NS 250
`define PBA_LONG_INT_NS 2000
`define PBA_REPEAT_NS 100000
`define PBA_MEAS_CYC 4'h8
`endif

// ---- rtl/pba_pkg.sv ----
// Types shared by the transient absorption block.
// Assumes nothing of its surroundings.
package pba_pkg;
   // Absorption sequencer states
   typedef enum logic [1:0] {
      PBA_ST_IDLE = 2'b00,
      PBA_ST_HOLD = 2'b01,
      PBA_ST_APPLY = 2'b10
   } pba_state_e;
   // Signed phase in picoseconds
   typedef logic signed [25:0] pba_phase_t;
endpackage : pba_pkg

// ---- rtl/pba_interval_timer.sv ----
// One-shot interval counter for phase movement monitoring.
// Assumes start and clear are synchronous single-cycle levels.
`include "pba_defines.svh"
module pba_interval_timer #(
   parameter int unsigned CYCLES = `PBA_INTERVAL_NS / `PBA_CLK_NS
) (
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_start,
   input wire logic i_clear,
   output logic o_running,
   output logic o_expired
);
   logic [21:0] cnt_r; // Elapsed cycles
   wire last = (cnt_r == 22'(CYCLES - 1)); // Final cycle of interval
   // ------------------------------
   // Counter
   // ------------------------------
   // Clear wins: a detection ends the window at once
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         cnt_r <= 22'h0;
         o_running <= 1'b0;
         o_expired <= 1'b0;
      end else begin
         o_expired <= o_running && last && !i_clear;
         if (i_clear || (o_running && last)) begin
            o_running <= 1'b0;
            cnt_r <= 22'h0;
         end else if (o_running) begin
            cnt_r <= cnt_r + 22'h1;
         end else if (i_start) begin
            o_running <= 1'b1;
         end
      end
   end
   // ------------------------------
   // Checks
   // ------------------------------
   property p_rearm;
      @(posedge i_mclk) disable iff (i_reset) o_expired |-> !o_running && (cnt_r == 22'h0);
   endproperty
   a_rearm: assert property (p_rearm) else $error("interval did not re-arm");
endmodule // pba_interval_timer

// ---- rtl/pba_ref_monitor.sv ----
// Activity and quality watch for one input reference.
// Assumes activity and quality levels are synchronous to i_mclk.
`include "pba_defines.svh"
module pba_ref_monitor (
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_active,
   input wire logic i_freq_bad,
   input wire logic i_quality_ok,
   output logic o_unserviceable
);
   localparam int LONG_CYC = (`PBA_LONG_INT_NS + `PBA_CLK_NS - 1) / `PBA_CLK_NS;
   localparam int REP_CYC = `PBA_REPEAT_NS / `PBA_CLK_NS;
   logic [11:0] gap_r; // Cycles without activity
   logic [11:0] since_r; // Cycles since last short gap
   logic seen_r; // One short gap already recorded
   wire long_gap = (gap_r >= 12'(LONG_CYC));
   wire short_end = i_active && (gap_r != 12'h0) && !long_gap;
   wire repeat_hit = short_end && seen_r && (since_r < 12'(REP_CYC));
   wire fail_set = long_gap || i_freq_bad || repeat_hit;
   wire fail_clr = i_quality_ok && i_active && !i_freq_bad;
   // ------------------------------
   // Gap tracking
   // ------------------------------
   // A lone short gap is tolerated; a second one close by is not
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         gap_r <= 12'h0;
         since_r <= 12'h0;
         seen_r <= 1'b0;
      end else begin
         gap_r <= i_active ? 12'h0 : (long_gap ? gap_r : gap_r + 12'h1);
         if (short_end) begin
            seen_r <= 1'b1;
            since_r <= 12'h0;
         end else if (seen_r) begin
            since_r <= since_r + 12'h1;
            seen_r <= (since_r < 12'(REP_CYC));
         end
      end
   end
   // ------------------------------
   // Unserviceable flag
   // ------------------------------
   // Set wins over restore in the same cycle
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         o_unserviceable <= 1'b0;
      end else if (fail_set) begin
         o_unserviceable <= 1'b1;
      end else if (fail_clr) begin
         o_unserviceable <= 1'b0;
      end
   end
endmodule // pba_ref_monitor

// ---- rtl/pba_top.sv ----
// Transient absorption and output phase adjust around the main DPLL.
// Assumes a synchronous register port and a phase error input in ps.
//
// Summary of operation
// - Loop bandwidth code limited to 18 settings
// - Lost reference switches and starts absorption
// - Trigger threshold programmable 1 to 3.5 us
// - Detection flagged; software may request absorption
// - Movement over 156 ns starts interval counter
// - Threshold inside interval auto-absorbs when enabled
// - Absorption: holdover, measure, add compensating offset
// - Output step after absorption within 5 ns
// - Enable, disable, freeze; enabled after reset
// - Freeze while enabled holds offset, ignores new events
// - Disable slews offset to zero by bandwidth
// - Enabling while locked triggers one absorption
// - Systematic offset 0.101 ns steps, +-1.313 ns
// - Output adjust 6 ps steps, -196.608 to +196.602 ns
// - Adjust acts through feedback clock phase
// - Adjust used only while absorption off
// - Long or repeated interruptions force reselection
// - Failed reference unserviceable until quality returns
// - All timing runs from system clock
`include "pba_defines.svh"
module pba_top #(
   parameter int unsigned INTERVAL_CYC = `PBA_INTERVAL_NS / `PBA_CLK_NS
) (
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic [3:0] i_ref_active,
   input wire logic [3:0] i_ref_freq_bad,
   input wire logic [3:0] i_ref_quality_ok,
   input wire logic i_locked,
   input wire pba_pkg::pba_phase_t i_phase_err,
   input wire logic [4:0] i_bw_sel,
   output logic [7:0] o_reg_rdata,
   output logic [1:0] o_selected_ref,
   output logic [3:0] o_ref_unserviceable,
   output logic o_holdover,
   output pba_pkg::pba_phase_t o_absorb_offset,
   output pba_pkg::pba_phase_t o_fb_phase_adj,
   output logic [4:0] o_bw_code,
   output logic o_transient_flag,
   output logic o_absorb_event
);
   // ------------------------------
   // Register state
   // ------------------------------
   logic en_r; // Absorption enabled
   logic en_d_r; // Enable one cycle ago, for edge
   logic frz_r; // Absorption frozen
   logic req_r; // Software absorption request pulse
   logic [3:0] thr_code_r; // Threshold code, 250 ns steps
   logic auto_en_r; // Automatic absorption enable
   logic auto_trig_r; // Automatic trigger on transients
   logic [7:0] adj_lo_r; // Output adjust, low byte
   logic [7:0] adj_hi_r; // Output adjust, high byte
   logic signed [7:0] sys_r; // Systematic offset steps
   pba_pkg::pba_state_e state_r; // Sequencer state
   pba_pkg::pba_state_e state_nxt;
   logic [3:0] meas_cnt_r; // Holdover measurement cycles
   pba_pkg::pba_phase_t meas_r; // Captured input phase
   logic [1:0] sel_r; // Selected reference index
   logic [1:0] pick; // Best serviceable reference
   logic pick_ok; // Any serviceable reference
   logic [3:0] unserv; // Monitor outputs
   logic running; // Interval counter active

   // ------------------------------
   // Decoding
   // ------------------------------
   wire wr_ctrl = i_reg_wr && (i_reg_addr == `PBA_OFF_CTRL);
   wire wr_thr = i_reg_wr && (i_reg_addr == `PBA_OFF_THR);
   wire wr_lo = i_reg_wr && (i_reg_addr == `PBA_OFF_ADJ_LO);
   wire wr_hi = i_reg_wr && (i_reg_addr == `PBA_OFF_ADJ_HI);
   wire wr_sys = i_reg_wr && (i_reg_addr == `PBA_OFF_SYS);
   // Clamp written fields into their legal ranges
   wire [3:0] thr_code_w = (i_reg_wdata[3:0] > `PBA_THR_CODE_MAX) ?
      `PBA_THR_CODE_MAX : i_reg_wdata[3:0];
   wire signed [7:0] sys_w_raw = $signed(i_reg_wdata);
   wire signed [7:0] sys_w = (sys_w_raw > `PBA_SYS_MAX) ? `PBA_SYS_MAX :
      ((sys_w_raw < -`PBA_SYS_MAX) ? -`PBA_SYS_MAX : sys_w_raw);
   wire signed [16:0] adj_raw = 17'($signed({adj_hi_r, adj_lo_r}));
   wire signed [16:0] adj_cl = (adj_raw > `PBA_ADJ_MAX) ? `PBA_ADJ_MAX :
      ((adj_raw < -`PBA_ADJ_MAX) ? -`PBA_ADJ_MAX : adj_raw);
   wire [4:0] bw_w = (i_bw_sel > `PBA_BW_MAX) ? `PBA_BW_MAX : i_bw_sel;

   // ------------------------------
   // Phase arithmetic
   // ------------------------------
   wire pba_pkg::pba_phase_t abs_err = i_phase_err[25] ? -i_phase_err : i_phase_err;
   wire pba_pkg::pba_phase_t move_ps = 26'(`PBA_MOVE_NS * 1000);
   wire pba_pkg::pba_phase_t thr_ps = 26'(`PBA_THR_BASE_NS * 1000) +
      26'(thr_code_r) * 26'(`PBA_THR_STEP_NS * 1000);
   wire pba_pkg::pba_phase_t sys_ps = 26'(sys_r) * 26'(`PBA_SYS_STEP_PS);
   wire pba_pkg::pba_phase_t adj_ps = 26'(adj_cl) * 26'(`PBA_ADJ_STEP_PS);
   wire pba_pkg::pba_phase_t slew = 26'(o_bw_code) + 26'h1; // ps per cycle
   wire pba_pkg::pba_phase_t off_mag = o_absorb_offset[25] ? -o_absorb_offset :
      o_absorb_offset;

   // ------------------------------
   // Event sources
   // ------------------------------
   wire idle = (state_r == pba_pkg::PBA_ST_IDLE);
   wire big_move = idle && (abs_err > move_ps);
   wire detect = running && (abs_err > thr_ps);
   wire sel_lost = unserv[sel_r] && pick_ok && (pick != sel_r);
   wire en_rise = en_r && !en_d_r && i_locked;
   wire auto_go = detect && auto_en_r && auto_trig_r;
   wire ev_any = sel_lost || auto_go || req_r || en_rise;
   // Frozen or disabled absorption ignores every event
   wire absorb_go = ev_any && en_r && !frz_r && idle;
   wire absorb_off = !en_r && !auto_en_r;

   // ------------------------------
   // Reference monitors
   // ------------------------------
   // One watcher per input; all share the system clock
   genvar g;
   generate
      for (g = 0; g < `PBA_NUM_REFS; g++) begin : g_ref
         pba_ref_monitor u_mon (
            .i_mclk(i_mclk),
            .i_reset(i_reset),
            .i_active(i_ref_active[g]),
            .i_freq_bad(i_ref_freq_bad[g]),
            .i_quality_ok(i_ref_quality_ok[g]),
            .o_unserviceable(unserv[g])
         );
      end
   endgenerate

   // Lowest index is highest priority; failed inputs are skipped
   always_comb begin
      pick = 2'h0;
      pick_ok = 1'b0;
      for (int i = `PBA_NUM_REFS - 1; i >= 0; i--) begin
         if (!unserv[i]) begin
            pick = 2'(i);
            pick_ok = 1'b1;
         end
      end
   end

   // ------------------------------
   // Interval counter
   // ------------------------------
   // Detection ends the window; expiry re-arms on its own
   pba_interval_timer #(
      .CYCLES(INTERVAL_CYC)
   ) u_timer (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .i_start(big_move),
      .i_clear(detect),
      .o_running(running),
      .o_expired() // Re-arm is handled inside the timer
   );

   // ------------------------------
   // Register writes
   // ------------------------------
   // Control and threshold fields
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         en_r <= `PBA_RST_EN;
         en_d_r <= `PBA_RST_EN;
         frz_r <= 1'b0;
         req_r <= 1'b0;
         thr_code_r <= `PBA_RST_THR_CODE;
         auto_en_r <= 1'b0;
         auto_trig_r <= 1'b0;
      end else begin
         en_d_r <= en_r;
         req_r <= wr_ctrl && i_reg_wdata[`PBA_CTRL_REQ];
         if (wr_ctrl) begin
            en_r <= i_reg_wdata[`PBA_CTRL_EN];
            frz_r <= i_reg_wdata[`PBA_CTRL_FRZ];
         end
         if (wr_thr) begin
            thr_code_r <= thr_code_w;
            auto_en_r <= i_reg_wdata[`PBA_THR_AUTO_EN];
            auto_trig_r <= i_reg_wdata[`PBA_THR_AUTO_TRIG];
         end
      end
   end

   // Offset fields
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         adj_lo_r <= 8'h00;
         adj_hi_r <= 8'h00;
         sys_r <= 8'sh00;
      end else begin
         if (wr_lo) adj_lo_r <= i_reg_wdata;
         if (wr_hi) adj_hi_r <= i_reg_wdata;
         if (wr_sys) sys_r <= sys_w;
      end
   end

   // Transient flag: detection wins over a write-one clear
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         o_transient_flag <= 1'b0;
      end else if (detect) begin
         o_transient_flag <= 1'b1;
      end else if (wr_ctrl && i_reg_wdata[`PBA_CTRL_FLAG]) begin
         o_transient_flag <= 1'b0;
      end
   end

   // ------------------------------
   // Reference selection
   // ------------------------------
   // Switch only when a better candidate really exists
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         sel_r <= 2'h0;
      end else if (sel_lost) begin
         sel_r <= pick;
      end
   end

   // ------------------------------
   // Absorption sequencer
   // ------------------------------
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         pba_pkg::PBA_ST_IDLE: begin
            if (absorb_go) state_nxt = pba_pkg::PBA_ST_HOLD;
         end
         pba_pkg::PBA_ST_HOLD: begin
            if (meas_cnt_r == `PBA_MEAS_CYC - 4'h1) state_nxt = pba_pkg::PBA_ST_APPLY;
         end
         pba_pkg::PBA_ST_APPLY: begin
            state_nxt = pba_pkg::PBA_ST_IDLE;
         end
         default: begin
            state_nxt = pba_pkg::PBA_ST_IDLE;
         end
      endcase
   end

   // State, measurement and holdover output
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         state_r <= pba_pkg::PBA_ST_IDLE;
         meas_cnt_r <= 4'h0;
         meas_r <= 26'sh0;
         o_holdover <= 1'b0;
         o_absorb_event <= 1'b0;
      end else begin
         state_r <= state_nxt;
         o_holdover <= (state_nxt == pba_pkg::PBA_ST_HOLD);
         o_absorb_event <= absorb_go;
         meas_cnt_r <= (state_r == pba_pkg::PBA_ST_HOLD) ? meas_cnt_r + 4'h1 : 4'h0;
         // Last holdover sample is taken as the input step
         if (state_r == pba_pkg::PBA_ST_HOLD) meas_r <= i_phase_err;
      end
   end

   // ------------------------------
   // Accumulated absorption offset
   // ------------------------------
   // Jump on apply keeps the output step small; disable slews back
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         o_absorb_offset <= 26'sh0;
      end else if (state_r == pba_pkg::PBA_ST_APPLY) begin
         o_absorb_offset <= o_absorb_offset + meas_r + sys_ps;
      end else if (!en_r && idle) begin
         if (off_mag <= slew) begin
            o_absorb_offset <= 26'sh0;
         end else if (o_absorb_offset[25]) begin
            o_absorb_offset <= o_absorb_offset + slew;
         end else begin
            o_absorb_offset <= o_absorb_offset - slew;
         end
      end
   end

   // ------------------------------
   // Feedback adjust and status
   // ------------------------------
   // The DPLL follows the feedback shift at its own bandwidth
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         o_fb_phase_adj <= 26'sh0;
         o_bw_code <= 5'h00;
         o_selected_ref <= 2'h0;
         o_ref_unserviceable <= 4'h0;
      end else begin
         o_fb_phase_adj <= absorb_off ? adj_ps : 26'sh0;
         o_bw_code <= bw_w;
         o_selected_ref <= sel_r;
         o_ref_unserviceable <= unserv;
      end
   end

   // ------------------------------
   // Register read
   // ------------------------------
   // One cycle of latency; unmapped offsets read zero
   wire [7:0] rd_ctrl = {3'h0, o_holdover, frz_r, en_r, 1'b0, o_transient_flag};
   wire [7:0] rd_thr = {1'b0, running, auto_trig_r, auto_en_r, thr_code_r};
   wire [7:0] rd_mux = (i_reg_addr == `PBA_OFF_CTRL) ? rd_ctrl :
      (i_reg_addr == `PBA_OFF_THR) ? rd_thr :
      (i_reg_addr == `PBA_OFF_ADJ_LO) ? adj_lo_r :
      (i_reg_addr == `PBA_OFF_ADJ_HI) ? adj_hi_r :
      (i_reg_addr == `PBA_OFF_SYS) ? sys_r : 8'h00;
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) o_reg_rdata <= 8'h00;
      else o_reg_rdata <= rd_mux;
   end

   // ------------------------------
   // Checks
   // ------------------------------
   property p_bw_range;
      @(posedge i_mclk) disable iff (i_reset) o_bw_code <= 5'h11;
   endproperty
   a_bw_range: assert property (p_bw_range) else $error("bandwidth code out of range");
   property p_switch_absorb;
      @(posedge i_mclk) disable iff (i_reset)
         sel_lost && en_r && !frz_r && idle |=> o_holdover && (sel_r == $past(pick));
   endproperty
   a_switch_absorb: assert property (p_switch_absorb) else $error("switch missed");
   property p_thr_range;
      @(posedge i_mclk) disable iff (i_reset)
         (thr_ps >= 26'sh00F4240) && (thr_ps <= 26'sh03567E0);
   endproperty
   a_thr_range: assert property (p_thr_range) else $error("threshold out of range");
   property p_flag_set;
      @(posedge i_mclk) disable iff (i_reset) detect |=> o_transient_flag;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("transient not flagged");
   property p_timer_start;
      @(posedge i_mclk) disable iff (i_reset) big_move && !running |=> running;
   endproperty
   a_timer_start: assert property (p_timer_start) else $error("interval not started");
   property p_auto_absorb;
      @(posedge i_mclk) disable iff (i_reset)
         auto_go && en_r && !frz_r && idle |=> o_holdover ##8 !o_holdover;
   endproperty
   a_auto_absorb: assert property (p_auto_absorb) else $error("auto absorb missed");
   property p_hold_len;
      @(posedge i_mclk) disable iff (i_reset)
         $rose(o_holdover) |-> o_holdover [*8] ##1 (state_r == pba_pkg::PBA_ST_APPLY);
   endproperty
   a_hold_len: assert property (p_hold_len) else $error("holdover length wrong");
   property p_apply_sum;
      @(posedge i_mclk) disable iff (i_reset)
         state_r == pba_pkg::PBA_ST_APPLY |=>
            o_absorb_offset == $past(o_absorb_offset) + $past(meas_r) + $past(sys_ps);
   endproperty
   a_apply_sum: assert property (p_apply_sum) else $error("offset not applied");
   property p_frozen;
      @(posedge i_mclk) disable iff (i_reset)
         frz_r && en_r && idle |=> $stable(o_absorb_offset) && !o_holdover;
   endproperty
   a_frozen: assert property (p_frozen) else $error("frozen offset moved");
   property p_adj_gate;
      @(posedge i_mclk) disable iff (i_reset) !absorb_off |=> o_fb_phase_adj == 26'sh0;
   endproperty
   a_adj_gate: assert property (p_adj_gate) else $error("adjust used while absorbing");
endmodule // pba_top

// ---- test/pba_ref_model.sv ----
// Far side model: input references and the DPLL feedback phase.
// Assumes the bench calls its tasks from one process at a time.
module pba_ref_model (
   input wire logic i_mclk,
   output logic [3:0] o_ref_active,
   output logic [3:0] o_ref_freq_bad,
   output logic [3:0] o_ref_quality_ok,
   output logic o_locked,
   output pba_pkg::pba_phase_t o_phase_err
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // Start state: all references healthy
   // ----------------------------------------
   initial begin
      o_ref_active = 4'hF;
      o_ref_freq_bad = 4'h0;
      o_ref_quality_ok = 4'hF;
      o_locked = 1'b1;
      o_phase_err = '0;
   end
   // Phase steps land just after an edge
   task automatic set_phase(input pba_pkg::pba_phase_t v);
      @(posedge i_mclk);
      o_phase_err <= v;
   endtask
   // Lock state of the DPLL as seen by the block
   task automatic set_lock(input logic l);
      @(posedge i_mclk);
      o_locked <= l;
   endtask
   // Bad frequency also drops quality
   task automatic set_bad(input int i, input logic b);
      @(posedge i_mclk);
      o_ref_freq_bad[i] <= b;
      o_ref_quality_ok[i] <= !b;
   endtask
   // Clock gap of n cycles on one reference
   task automatic gap(input int i, input int n);
      @(posedge i_mclk);
      o_ref_active[i] <= 1'b0;
      repeat (n) @(posedge i_mclk);
      o_ref_active[i] <= 1'b1;
   endtask
endmodule // pba_ref_model

// ---- test/tb.sv ----
// Self-checking bench for the transient absorption block.
// Assumes the reference model on the far side; short interval count.
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr_en = 1'b0;
   logic [4:0] bw = 5'h03;
   logic [3:0] act, bad, qok, unserv;
   logic locked, hold, flag, evt;
   logic [7:0] rdata;
   logic [1:0] sel;
   logic [4:0] bw_code;
   pba_pkg::pba_phase_t perr, off, fb;
   int n_fail = 0;
   int total_checks = 0;
   int n_evt = 0;
   // Short interval keeps the run brief
   pba_top #(.INTERVAL_CYC(200)) i_dut (.i_mclk(mclk), .i_reset(rst), .i_reg_addr(addr),
      .i_reg_wdata(wdata), .i_reg_wr(wr_en), .i_ref_active(act), .i_ref_freq_bad(bad),
      .i_ref_quality_ok(qok), .i_locked(locked), .i_phase_err(perr), .i_bw_sel(bw),
      .o_reg_rdata(rdata), .o_selected_ref(sel), .o_ref_unserviceable(unserv),
      .o_holdover(hold), .o_absorb_offset(off), .o_fb_phase_adj(fb), .o_bw_code(bw_code),
      .o_transient_flag(flag), .o_absorb_event(evt));
   pba_ref_model i_refs (.i_mclk(mclk), .o_ref_active(act), .o_ref_freq_bad(bad),
      .o_ref_quality_ok(qok), .o_locked(locked), .o_phase_err(perr));
   always #20 mclk = ~mclk;
   // Count absorption pulses
   always @(posedge mclk) begin
      if (evt === 1'b1) n_evt++;
   end
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         n_fail++;
         $display("wrong value %s expected %0d seen %0d", nm, e, s);
      end
   endtask
   // Let n edges pass, then sample settled outputs
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge mclk);
      wr_en <= 1'b0;
   endtask
   // Read data is registered one cycle after the address
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
      @(posedge mclk);
      addr <= a;
      cyc(1);
      chk(nm, rdata, e);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_request;
      int e0;
      e0 = n_evt;
      i_refs.set_phase(26'sd1000);
      wr(8'h72, 8'h03);
      wr(8'h48, 8'h06);
      cyc(14);
      chk("req event", n_evt - e0, 1);
      chk("req offset", off, 1303);
   endtask
   task automatic t_auto;
      int e0;
      e0 = n_evt;
      wr(8'h76, 8'h32);
      i_refs.set_phase(26'sd200000);
      i_refs.set_phase(26'sd1000);
      rd(8'h76, 8'h72, "running");
      cyc(205);
      rd(8'h76, 8'h32, "rearmed");
      i_refs.set_phase(26'sd1400000);
      cyc(4);
      chk("below thr", n_evt - e0, 0);
      i_refs.set_phase(26'sd1600000);
      cyc(4);
      i_refs.set_phase(26'sd1000);
      cyc(12);
      chk("auto event", n_evt - e0, 1);
      chk("auto offset", off, 2606);
      rd(8'h48, 8'h05, "flag");
      wr(8'h48, 8'h05);
      rd(8'h48, 8'h04, "flag clr");
   endtask
   task automatic t_freeze;
      int e0;
      e0 = n_evt;
      wr(8'h48, 8'h0C);
      wr(8'h48, 8'h0E);
      cyc(12);
      chk("frozen ev", n_evt - e0, 0);
      chk("frozen off", off, 2606);
   endtask
   task automatic t_adjust;
      int o1;
      int e0;
      wr(8'h70, 8'h00);
      wr(8'h71, 8'h01);
      wr(8'h48, 8'h00);
      cyc(2);
      chk("adj auto on", fb, 0);
      wr(8'h76, 8'h00);
      cyc(2);
      chk("adj off", fb, 1536);
      wr(8'h70, 8'hFF);
      wr(8'h71, 8'h7F);
      cyc(2);
      chk("adj max", fb, 196602);
      o1 = off;
      cyc(1);
      chk("slew", o1 - off, 4);
      @(posedge mclk);
      bw <= 5'h1F;
      cyc(2);
      chk("bw clamp", bw_code, 17);
      e0 = n_evt;
      i_refs.set_lock(1'b0);
      wr(8'h48, 8'h04);
      cyc(14);
      chk("unlocked ev", n_evt - e0, 0);
      wr(8'h48, 8'h00);
      i_refs.set_lock(1'b1);
      wr(8'h48, 8'h04);
      cyc(14);
      chk("enable ev", n_evt - e0, 1);
   endtask
   task automatic t_ref;
      int e0;
      e0 = n_evt;
      i_refs.set_bad(0, 1'b1);
      cyc(6);
      chk("unserv", unserv, 4'h1);
      chk("select", sel, 2'h1);
      cyc(10);
      chk("switch ev", n_evt - e0, 1);
      i_refs.set_bad(0, 1'b0);
      i_refs.gap(1, 10);
      cyc(4);
      chk("restored", unserv, 4'h0);
      chk("single gap", sel, 2'h1);
      e0 = n_evt;
      i_refs.gap(1, 10);
      cyc(6);
      chk("repeat sel", sel, 2'h0);
      chk("repeat ev", n_evt - e0, 1);
      i_refs.gap(2, 60);
      cyc(0);
      chk("long gap", unserv, 4'h4);
      cyc(4);
      chk("long back", unserv, 4'h0);
      i_refs.set_bad(3, 1'b1);
      cyc(3);
      chk("freq bad", unserv, 4'h8);
      i_refs.set_bad(3, 1'b0);
      cyc(3);
      chk("freq back", unserv, 4'h0);
   endtask
   // ----------------------------------------
   // Verdict, watchdog and main sequence
   // ----------------------------------------
   task automatic conclude;
      if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Whole run needs well under 1000 cycles
   initial begin
      repeat (4000) @(posedge mclk);
      n_fail++;
      conclude();
   end
   initial begin
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      rd(8'h48, 8'h04, "ctrl rst");
      rd(8'h76, 8'h00, "thr rst");
      rd(8'h50, 8'h00, "unmapped");
      t_request();
      t_auto();
      t_freeze();
      t_adjust();
      t_ref();
      conclude();
   end
endmodule // tb
